// [core/interrupt_priority_fields.sv]
`timescale 1ns/100ps

module interrupt_priority_fields
#(
  parameter int ADDR_WIDTH = prio_bank_pkg::ADDR_WIDTH
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic [2:0] crc_error_prio,
  output logic crc_error_enable,
  output logic [2:0] serial2_error_prio,
  output logic serial2_error_enable,
  output logic [2:0] serial1_error_prio,
  output logic serial1_error_enable,
  output logic [2:0] low_voltage_prio,
  output logic low_voltage_enable,
  output logic [2:0] charge_measure_prio,
  output logic charge_measure_enable,
  output logic [2:0] serial3_tx_prio,
  output logic serial3_tx_enable,
  output logic [2:0] serial3_rx_prio,
  output logic serial3_rx_enable,
  output logic [2:0] serial3_error_prio,
  output logic serial3_error_enable,
  output logic [2:0] serial4_error_prio,
  output logic serial4_error_enable,
  output logic [2:0] i2c3_master_prio,
  output logic i2c3_master_enable,
  output logic [2:0] i2c3_slave_prio,
  output logic i2c3_slave_enable,
  output logic [2:0] spi3_event_prio,
  output logic spi3_event_enable,
  output logic [2:0] spi3_fault_prio,
  output logic spi3_fault_enable,
  output logic [2:0] serial4_tx_prio,
  output logic serial4_tx_enable,
  output logic [2:0] serial4_rx_prio,
  output logic serial4_rx_enable
);

  localparam int NF = prio_bank_pkg::NUM_FIELDS;
  localparam int NR = prio_bank_pkg::NUM_REGS;

  // offsets are four bits wide, so the address must hold them
  if (ADDR_WIDTH < 4)
  begin : addr_width_check
    $error("ADDR_WIDTH too small for the register offsets");
  end

  logic [2:0] field_level [NF];
  logic field_on [NF];
  logic [NR-1:0] reg_hit;
  logic [15:0] read_word;
  logic [15:0] reg_rdata_reg;
  logic [15:0] reg_rdata_next;

  // true when the address selects register r
  function automatic logic addr_selects(input logic [ADDR_WIDTH-1:0] addr, input int r);
    addr_selects = (addr == ADDR_WIDTH'(prio_bank_pkg::REG_OFFSET[r]));
  endfunction

  // address decode, one bit per register
  always_comb
  begin
    for (int r = 0; r < NR; r++)
      reg_hit[r] = addr_selects(reg_addr, r);
  end

  // one field register per source at its fixed register and bit position
  for (genvar f = 0; f < NF; f++)
  begin : field_gen
    prio_field u_field
    (
      .clk_sys(clk_sys),
      .reset(reset),
      .write_en(reg_write && reg_hit[prio_bank_pkg::FIELD_REG[f]]),
      .write_value(reg_wdata[prio_bank_pkg::FIELD_LSB[f] +: 3]),
      .level(field_level[f]),
      .enabled(field_on[f])
    );
  end

  // read word: fields placed at their bit positions, the rest zero
  always_comb
  begin
    read_word = 16'h0000;
    for (int f = 0; f < NF; f++)
    begin
      if (reg_hit[prio_bank_pkg::FIELD_REG[f]])
        read_word[prio_bank_pkg::FIELD_LSB[f] +: 3] = field_level[f];
    end
  end

  // read data stands for exactly the cycle after the read strobe
  assign reg_rdata_next = reg_read ? read_word : 16'h0000;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      reg_rdata_reg <= 16'h0000;
    else
      reg_rdata_reg <= reg_rdata_next;
  end

  assign reg_rdata = reg_rdata_reg;

  // per-source outputs straight from the field flops
  assign crc_error_prio = field_level[0];
  assign crc_error_enable = field_on[0];
  assign serial2_error_prio = field_level[1];
  assign serial2_error_enable = field_on[1];
  assign serial1_error_prio = field_level[2];
  assign serial1_error_enable = field_on[2];
  assign low_voltage_prio = field_level[3];
  assign low_voltage_enable = field_on[3];
  assign charge_measure_prio = field_level[4];
  assign charge_measure_enable = field_on[4];
  assign serial3_tx_prio = field_level[5];
  assign serial3_tx_enable = field_on[5];
  assign serial3_rx_prio = field_level[6];
  assign serial3_rx_enable = field_on[6];
  assign serial3_error_prio = field_level[7];
  assign serial3_error_enable = field_on[7];
  assign serial4_error_prio = field_level[8];
  assign serial4_error_enable = field_on[8];
  assign i2c3_master_prio = field_level[9];
  assign i2c3_master_enable = field_on[9];
  assign i2c3_slave_prio = field_level[10];
  assign i2c3_slave_enable = field_on[10];
  assign spi3_event_prio = field_level[11];
  assign spi3_event_enable = field_on[11];
  assign spi3_fault_prio = field_level[12];
  assign spi3_fault_enable = field_on[12];
  assign serial4_tx_prio = field_level[13];
  assign serial4_tx_enable = field_on[13];
  assign serial4_rx_prio = field_level[14];
  assign serial4_rx_enable = field_on[14];

  // helper: cycles since reset release, saturating
  logic [3:0] since_reset;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      since_reset <= 4'h0;
    else if (since_reset != 4'hF)
      since_reset <= since_reset + 4'h1;
  end

  // helper: mask of the register the address selects in this cycle
  logic [15:0] past_mask;

  always_comb
  begin
    past_mask = 16'h0000;
    for (int r = 0; r < NR; r++)
    begin
      if (reg_hit[r])
        past_mask = prio_bank_pkg::REG_MASK[r];
    end
  end

  // crc, low-voltage and serial4 rx sit at level 4 in the first cycle after reset, crc and serial4 rx enabled
  reset_level_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (since_reset == 4'h0) |-> (crc_error_prio == 3'h4 && serial4_rx_prio == 3'h4
      && low_voltage_prio == 3'h4 && crc_error_enable && serial4_rx_enable))
    else $error("field not at level 4 after reset");

  // a write of 111 shows level 7, enabled, on the next cycle
  level_seven_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && reg_hit[0] && reg_wdata[14:12] == 3'h7)
      |=> (crc_error_prio == 3'h7 && crc_error_enable))
    else $error("all-ones field did not give level 7");

  // a write of 001 shows level 1, still enabled
  level_one_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && reg_hit[5] && reg_wdata[2:0] == 3'h1)
      |=> (serial4_rx_prio == 3'h1 && serial4_rx_enable))
    else $error("field 001 did not give enabled level 1");

  // zero disables the source and only zero does
  zero_disables_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (low_voltage_enable == (low_voltage_prio != 3'h0))
      && (charge_measure_enable == (charge_measure_prio != 3'h0)))
    else $error("enable flag disagrees with level");

  // unimplemented bits of every read word stay zero
  unused_zero_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    $past(reg_read) |-> ((reg_rdata & ~$past(past_mask)) == 16'h0000))
    else $error("unimplemented bit read as one");

  // read data is zero in any cycle not following a read
  idle_read_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    !$past(reg_read) |-> (reg_rdata == 16'h0000))
    else $error("read data outside its cycle");

  // crc/serial error fields land at 14:12, 10:8 and 6:4
  crc_layout_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && reg_hit[0]) |=> (crc_error_prio == $past(reg_wdata[14:12])
      && serial2_error_prio == $past(reg_wdata[10:8]) && serial1_error_prio == $past(reg_wdata[6:4])))
    else $error("crc register fields misplaced");

  // low-voltage field at 2:0 and charge-measure at 6:4
  single_layout_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && (reg_hit[1] || reg_hit[2]))
      |=> ((!$past(reg_hit[1]) || low_voltage_prio == $past(reg_wdata[2:0]))
      && (!$past(reg_hit[2]) || charge_measure_prio == $past(reg_wdata[6:4]))))
    else $error("single-field register misplaced");

  // serial3 fields at 14:12, 10:8, 6:4
  serial3_layout_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && reg_hit[3]) |=> (serial3_tx_prio == $past(reg_wdata[14:12])
      && serial3_rx_prio == $past(reg_wdata[10:8]) && serial3_error_prio == $past(reg_wdata[6:4])))
    else $error("serial3 register fields misplaced");

  // serial4 error and i2c3 fields at 14:12, 6:4, 2:0
  i2c3_layout_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && reg_hit[4]) |=> (serial4_error_prio == $past(reg_wdata[14:12])
      && i2c3_master_prio == $past(reg_wdata[6:4]) && i2c3_slave_prio == $past(reg_wdata[2:0])))
    else $error("i2c3 register fields misplaced");

  // spi3 and serial4 fields at 14:12, 10:8, 6:4, 2:0
  spi3_layout_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && reg_hit[5]) |=> (spi3_event_prio == $past(reg_wdata[14:12])
      && spi3_fault_prio == $past(reg_wdata[10:8]) && serial4_tx_prio == $past(reg_wdata[6:4])
      && serial4_rx_prio == $past(reg_wdata[2:0])))
    else $error("spi3 register fields misplaced");

  // a level holds steady while no write reaches its register
  level_steady_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    !(reg_write && reg_hit[3]) |=> $stable(serial3_rx_prio))
    else $error("level changed without a write");

  // reading back returns what the previous write stored
  readback_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && reg_hit[5]) ##1 (reg_read && $past(reg_addr) == reg_addr)
      |=> (reg_rdata == ($past(reg_wdata, 2) & 16'h7777)))
    else $error("read back differs from write");

  // crc/serial error word reads back its three fields and zeros
  crc_read_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_read && reg_hit[0]) |=> (reg_rdata == {1'h0, $past(crc_error_prio), 1'h0, $past(serial2_error_prio),
      1'h0, $past(serial1_error_prio), 4'h0}))
    else $error("crc register read word wrong");

  // low-voltage word reads its field at 2:0 only
  low_voltage_read_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_read && reg_hit[1]) |=> (reg_rdata == {13'h0000, $past(low_voltage_prio)}))
    else $error("low-voltage read word wrong");

  // charge-measure word reads its field at 6:4 only
  charge_read_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_read && reg_hit[2]) |=> (reg_rdata == {9'h000, $past(charge_measure_prio), 4'h0}))
    else $error("charge-measure read word wrong");

  // serial3 word reads tx, rx and error fields
  serial3_read_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_read && reg_hit[3]) |=> (reg_rdata == {1'h0, $past(serial3_tx_prio), 1'h0, $past(serial3_rx_prio),
      1'h0, $past(serial3_error_prio), 4'h0}))
    else $error("serial3 read word wrong");

  // serial4 error and i2c3 word
  i2c3_read_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_read && reg_hit[4]) |=> (reg_rdata == {1'h0, $past(serial4_error_prio), 5'h00, $past(i2c3_master_prio),
      1'h0, $past(i2c3_slave_prio)}))
    else $error("i2c3 read word wrong");

  // spi3 and serial4 word, all four fields
  spi3_read_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_read && reg_hit[5]) |=> (reg_rdata == {1'h0, $past(spi3_event_prio), 1'h0, $past(spi3_fault_prio),
      1'h0, $past(serial4_tx_prio), 1'h0, $past(serial4_rx_prio)}))
    else $error("spi3 read word wrong");

  // an unmapped offset reads as zero
  unmapped_read_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_read && !(|reg_hit)) |=> (reg_rdata == 16'h0000))
    else $error("unmapped offset read nonzero");

  // a write to an unmapped offset leaves the fields alone
  unmapped_write_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && !(|reg_hit)) |=> ($stable(crc_error_prio) && $stable(low_voltage_prio)
      && $stable(charge_measure_prio) && $stable(serial3_tx_prio) && $stable(i2c3_slave_prio)
      && $stable(spi3_event_prio) && $stable(serial4_rx_prio)))
    else $error("unmapped write changed a field");

  // enable flags of further sources follow their levels
  enable_follow_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (crc_error_enable == (crc_error_prio != 3'h0)) && (serial3_tx_enable == (serial3_tx_prio != 3'h0))
      && (i2c3_slave_enable == (i2c3_slave_prio != 3'h0)) && (spi3_fault_enable == (spi3_fault_prio != 3'h0))
      && (serial4_tx_enable == (serial4_tx_prio != 3'h0)))
    else $error("enable flag disagrees with level");

  // a write of 000 disables the i2c3 master source on the next cycle
  zero_write_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_write && reg_hit[4] && reg_wdata[6:4] == 3'h0) |=> (i2c3_master_prio == 3'h0 && !i2c3_master_enable))
    else $error("zero field left source enabled");

  // spi3 and serial4 levels hold while their register is not written
  spi3_steady_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    !(reg_write && reg_hit[5]) |=> ($stable(spi3_event_prio) && $stable(serial4_rx_prio)))
    else $error("level changed without a write");

endmodule

// [core/prio_bank_pkg.sv]
package prio_bank_pkg;

  // bus and field geometry
  localparam int DATA_WIDTH = 16;
  localparam int ADDR_WIDTH = 4;
  localparam int FIELD_WIDTH = 3;
  localparam int NUM_REGS = 6;
  localparam int NUM_FIELDS = 15;

  // value every priority field takes at power-on: level 4
  localparam logic [2:0] FIELD_RESET = 3'h4;
  localparam logic [2:0] FIELD_DISABLED = 3'h0;
  localparam logic [2:0] FIELD_LOWEST = 3'h1;
  localparam logic [2:0] FIELD_HIGHEST = 3'h7;

  // register offsets on the plain register port
  localparam logic [3:0] PRIO_CRC_UART_ERRORS_OFFSET = 4'h0;
  localparam logic [3:0] PRIO_LOW_VOLTAGE_OFFSET = 4'h1;
  localparam logic [3:0] PRIO_CHARGE_MEASURE_OFFSET = 4'h2;
  localparam logic [3:0] PRIO_SERIAL_THREE_OFFSET = 4'h3;
  localparam logic [3:0] PRIO_SERIAL4_ERR_I2C3_OFFSET = 4'h4;
  localparam logic [3:0] PRIO_SPI3_SERIAL4_OFFSET = 4'h5;

  localparam logic [3:0] REG_OFFSET [NUM_REGS] = '{
    PRIO_CRC_UART_ERRORS_OFFSET, PRIO_LOW_VOLTAGE_OFFSET, PRIO_CHARGE_MEASURE_OFFSET,
    PRIO_SERIAL_THREE_OFFSET, PRIO_SERIAL4_ERR_I2C3_OFFSET, PRIO_SPI3_SERIAL4_OFFSET};

  // implemented bits of each register; the rest read as zero
  localparam logic [15:0] REG_MASK [NUM_REGS] = '{
    16'h7770, 16'h0007, 16'h0070, 16'h7770, 16'h7077, 16'h7777};

  // field order: crc, serial2 err, serial1 err, low voltage, charge measure,
  // serial3 tx, rx, err, serial4 err, i2c3 master, slave,
  // spi3 event, fault, serial4 tx, rx
  localparam int FIELD_REG [NUM_FIELDS] = '{0, 0, 0, 1, 2, 3, 3, 3, 4, 4, 4, 5, 5, 5, 5};
  localparam int FIELD_LSB [NUM_FIELDS] = '{12, 8, 4, 0, 4, 12, 8, 4, 12, 4, 0, 12, 8, 4, 0};

  // a field of zero disables its source
  function automatic logic field_enabled(input logic [2:0] value);
    field_enabled = (value != FIELD_DISABLED);
  endfunction

endpackage

// [core/prio_field.sv]
`timescale 1ns/100ps

// one 3-bit priority field with its enable decode held in flops
module prio_field
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic write_en,
  input wire logic [2:0] write_value,
  output logic [2:0] level,
  output logic enabled
);

  logic [2:0] level_reg;
  logic enabled_reg;

  // stored level, loaded by a write
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      level_reg <= prio_bank_pkg::FIELD_RESET;
    else if (write_en)
      level_reg <= write_value;
  end

  // enable flag tracks the stored level in the same cycle
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      enabled_reg <= 1'b1;
    else if (write_en)
      enabled_reg <= prio_bank_pkg::field_enabled(write_value);
  end

  assign level = level_reg;
  assign enabled = enabled_reg;

endmodule

// [sim/interrupt_priority_fields_tb.sv]
`timescale 1ns/100ps

module interrupt_priority_fields_tb;
  localparam logic [15:0] MSK [6] = '{16'h7770, 16'h0007, 16'h0070, 16'h7770, 16'h7077, 16'h7777};
  localparam int FREG [15] = '{0, 0, 0, 1, 2, 3, 3, 3, 4, 4, 4, 5, 5, 5, 5};
  localparam int FLSB [15] = '{12, 8, 4, 0, 4, 12, 8, 4, 12, 4, 0, 12, 8, 4, 0};
  localparam logic [15:0] PATS [2] = '{16'h9AC5, 16'h7316};

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [prio_bank_pkg::ADDR_WIDTH-1:0] reg_addr = '0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic [2:0] prio_o [15];
  logic en_o [15];
  logic [15:0] m [6];
  logic rd_q = 1'b0;
  logic [15:0] rd_exp = 16'h0000;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  // clock at 250 MHz
  always #2 clk_sys = ~clk_sys;

  interrupt_priority_fields interrupt_priority_fields_inst
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .crc_error_prio(prio_o[0]),
    .crc_error_enable(en_o[0]),
    .serial2_error_prio(prio_o[1]),
    .serial2_error_enable(en_o[1]),
    .serial1_error_prio(prio_o[2]),
    .serial1_error_enable(en_o[2]),
    .low_voltage_prio(prio_o[3]),
    .low_voltage_enable(en_o[3]),
    .charge_measure_prio(prio_o[4]),
    .charge_measure_enable(en_o[4]),
    .serial3_tx_prio(prio_o[5]),
    .serial3_tx_enable(en_o[5]),
    .serial3_rx_prio(prio_o[6]),
    .serial3_rx_enable(en_o[6]),
    .serial3_error_prio(prio_o[7]),
    .serial3_error_enable(en_o[7]),
    .serial4_error_prio(prio_o[8]),
    .serial4_error_enable(en_o[8]),
    .i2c3_master_prio(prio_o[9]),
    .i2c3_master_enable(en_o[9]),
    .i2c3_slave_prio(prio_o[10]),
    .i2c3_slave_enable(en_o[10]),
    .spi3_event_prio(prio_o[11]),
    .spi3_event_enable(en_o[11]),
    .spi3_fault_prio(prio_o[12]),
    .spi3_fault_enable(en_o[12]),
    .serial4_tx_prio(prio_o[13]),
    .serial4_tx_enable(en_o[13]),
    .serial4_rx_prio(prio_o[14]),
    .serial4_rx_enable(en_o[14])
  );

  task automatic err(input string s);
    $display("wrong value at %0t: %s", $time, s);
    num_errors++;
  endtask

  // reference bank, compared against every output each cycle
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      for (int r = 0; r < 6; r++)
        m[r] <= 16'h4444 & MSK[r];
      rd_q <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 15; i++)
      begin
        num_checks++;
        if (prio_o[i] !== m[FREG[i]][FLSB[i] +: 3])
          err($sformatf("level of source %0d", i));
        if (en_o[i] !== (m[FREG[i]][FLSB[i] +: 3] != 3'h0))
          err($sformatf("enable of source %0d", i));
      end
      num_checks++;
      if (reg_rdata !== (rd_q ? rd_exp : 16'h0000))
        err($sformatf("read data %h", reg_rdata));
      rd_q <= reg_read;
      rd_exp <= (reg_addr < 6) ? m[reg_addr] : 16'h0000;
      if (reg_write && reg_addr < 6)
        m[reg_addr] <= reg_wdata & MSK[reg_addr];
    end
  end

  // bus cycles: each one sets both strobes, so ops may run back to back
  task automatic wr(input int a, input logic [15:0] d);
    reg_write <= 1'b1;
    reg_read <= 1'b0;
    reg_addr <= a[prio_bank_pkg::ADDR_WIDTH-1:0];
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask

  task automatic rd(input int a);
    reg_read <= 1'b1;
    reg_write <= 1'b0;
    reg_addr <= a[prio_bank_pkg::ADDR_WIDTH-1:0];
    @(posedge clk_sys);
  endtask

  task automatic idle();
    reg_read <= 1'b0;
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  // reads every offset including the unmapped ones
  task automatic read_all();
    for (int a = 0; a < 16; a++)
      rd(a);
    idle();
  endtask

  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_sim();
    end
  end

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    read_all();
    for (int a = 0; a < 16; a++)
      wr(a, 16'hFFFF);
    read_all();
    for (int v = 0; v < 8; v++)
    begin
      for (int r = 0; r < 6; r++)
        wr(r, {1'b1, v[2:0], 1'b1, v[2:0], 1'b1, v[2:0], 1'b1, v[2:0]});
      read_all();
    end
    for (int p = 0; p < 2; p++)
    begin
      for (int r = 0; r < 6; r++)
        wr(r, PATS[p]);
      for (int a = 6; a < 16; a++)
        wr(a, 16'h0000);
      read_all();
    end
    wr(5, 16'h3A5C);
    rd(5);
    idle();
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    read_all();
    idle();
    end_sim();
  end
endmodule
